//--- fsp_pkg.sv
// Shared constants for the flash operation status host controller.
// Assumes a 10 MHz system clock and a 16-bit parallel NOR flash with async strobes.
package fsp_pkg;

    // Status register field positions.
    localparam int unsigned BIT_READY         = 7;
    localparam int unsigned BIT_ERASE_SUSP    = 6;
    localparam int unsigned BIT_ERASE_RESULT  = 5;
    localparam int unsigned BIT_PROG_RESULT   = 4;
    localparam int unsigned BIT_BUFFER_ABORT  = 3;
    localparam int unsigned BIT_PROG_SUSP     = 2;
    localparam int unsigned BIT_SECTOR_LOCKED = 1;
    localparam int unsigned BIT_CONTINUITY    = 0;

    // Polling word bit positions.
    localparam int unsigned BIT_POLLING       = 7;
    localparam int unsigned BIT_TOGGLE_ONE    = 6;
    localparam int unsigned BIT_ERASE_TIMER   = 3;
    localparam int unsigned BIT_TOGGLE_TWO    = 2;

    // Masks applied by the host to status and polling words.
    localparam logic [15:0] STATUS_KEEP_MASK  = 16'h00FF;
    localparam logic [15:0] NOT_READY_MASK    = 16'h0081;
    localparam logic [15:0] POLL_KEEP_MASK    = 16'h00EE;

    // Status register read command and its address.
    localparam logic [15:0] CMD_STATUS_READ   = 16'h0070;
    localparam logic [15:0] CMD_STATUS_ADDR   = 16'h0555;

    // Strobe timing.
    localparam int unsigned CLK_MHZ           = 10;
    localparam int unsigned T_RD_STROBE_NS    = 110;
    localparam int unsigned T_WR_STROBE_NS    = 35;
    localparam int unsigned CYC_RD_STROBE     = (T_RD_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CYC_WR_STROBE     = (T_WR_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned POLL_MAX_DEFAULT  = 65535;

    // User operations.
    typedef enum logic [2:0] {
        OP_WRITE   = 3'h0,
        OP_READ    = 3'h1,
        OP_STATUS  = 3'h2,
        OP_SUSPEND = 3'h3,
        OP_POLL    = 3'h4
    } fsp_op_t;

    // Bus cycle states.
    typedef enum logic [3:0] {
        BC_IDLE   = 4'h1,
        BC_SETUP  = 4'h2,
        BC_STROBE = 4'h4,
        BC_HOLD   = 4'h8
    } fsp_bc_t;

    // Controller states.
    typedef enum logic [8:0] {
        HS_IDLE   = 9'h001,
        HS_WR     = 9'h002,
        HS_RD     = 9'h004,
        HS_ST_CMD = 9'h008,
        HS_ST_RD  = 9'h010,
        HS_POLL_A = 9'h020,
        HS_POLL_B = 9'h040,
        HS_POLL_C = 9'h080,
        HS_DONE   = 9'h100
    } fsp_hs_t;

endpackage : fsp_pkg

//--- fsp_bus_cycle.sv
// One asynchronous flash bus cycle: read or write under chip, output and write enables.
// Assumes the flash data pins are resolved outside from dq_o and dq_oe.
`timescale 1ns/10ps
module fsp_bus_cycle #(
    parameter int unsigned AW = 26,
    parameter int unsigned DW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic          clk_en,
    input  wire logic          start,
    input  wire logic          is_wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic [DW-1:0]      rdata,
    output logic               flash_ce_n,
    output logic               flash_oe_n,
    output logic               flash_we_n,
    output logic [AW-1:0]      flash_addr,
    input  wire logic [DW-1:0] flash_dq_i,
    output logic [DW-1:0]      flash_dq_o,
    output logic               flash_dq_oe
);

    initial
    begin
        if (DW != 16 || AW < 12)
            $error("fsp_bus_cycle: unsupported widths");
    end

    fsp_pkg::fsp_bc_t st_r, st_nxt;
    logic [3:0]       cnt_r, cnt_nxt;
    logic             wr_r, wr_nxt;
    logic [AW-1:0]    addr_r, addr_nxt;
    logic [DW-1:0]    wdata_r, wdata_nxt;
    logic [DW-1:0]    rdata_r, rdata_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        wr_nxt    = wr_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        case (st_r)
            fsp_pkg::BC_IDLE:
            begin
                if (start)
                begin
                    st_nxt    = fsp_pkg::BC_SETUP;
                    wr_nxt    = is_wr;
                    addr_nxt  = addr;
                    wdata_nxt = wdata;
                end
            end
            fsp_pkg::BC_SETUP:
            begin
                st_nxt  = fsp_pkg::BC_STROBE;
                cnt_nxt = wr_r ? 4'(fsp_pkg::CYC_WR_STROBE) : 4'(fsp_pkg::CYC_RD_STROBE);
            end
            fsp_pkg::BC_STROBE:
            begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r <= 4'h1)
                begin
                    st_nxt    = fsp_pkg::BC_HOLD;
                    rdata_nxt = wr_r ? rdata_r : flash_dq_i;
                end
            end
            fsp_pkg::BC_HOLD: st_nxt = fsp_pkg::BC_IDLE;
            default:          st_nxt = fsp_pkg::BC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r    <= fsp_pkg::BC_IDLE;
            cnt_r   <= 4'h0;
            wr_r    <= 1'b0;
            addr_r  <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
        end
        else if (clk_en)
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            wr_r    <= wr_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Each strobed read is a separate cycle, so the device sees every read edge.
    assign done        = clk_en && (st_r == fsp_pkg::BC_HOLD);
    assign rdata       = rdata_r;
    assign flash_ce_n  = (st_r != fsp_pkg::BC_STROBE);
    assign flash_oe_n  = !((st_r == fsp_pkg::BC_STROBE) && !wr_r);
    assign flash_we_n  = !((st_r == fsp_pkg::BC_STROBE) && wr_r);
    assign flash_addr  = addr_r;
    assign flash_dq_o  = wdata_r;
    assign flash_dq_oe = wr_r && (st_r != fsp_pkg::BC_IDLE);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    strobe_excl_a: assert property (!(!flash_oe_n && !flash_we_n))
        else $error("output and write enables low together");
    write_drive_a: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
        else $error("write strobe without data drive");
    read_release_a: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("data driven during read");

endmodule : fsp_bus_cycle

//--- fsp_host_ctrl.sv
// Host controller that drives a parallel NOR flash and reports embedded operation status.
// Assumes user commands arrive synchronous to clk_sys and the flash pins are joined outside.
`timescale 1ns/10ps
module fsp_host_ctrl #(
    parameter int unsigned AW       = 26,
    parameter int unsigned DW       = 16,
    parameter int unsigned POLL_MAX = fsp_pkg::POLL_MAX_DEFAULT
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    input  wire logic             cmd_valid,
    output logic                  cmd_ready,
    input  wire fsp_pkg::fsp_op_t cmd_op,
    input  wire logic [AW-1:0]    cmd_addr,
    input  wire logic [DW-1:0]    cmd_data,
    output logic                  rsp_valid,
    output logic [DW-1:0]         rsp_data,
    output logic                  rsp_ready_flag,
    output logic                  rsp_fail,
    output logic                  rsp_timeout,
    output logic                  rsp_toggle_two,
    output logic                  rsp_erase_timer,
    output logic                  flash_ce_n,
    output logic                  flash_oe_n,
    output logic                  flash_we_n,
    output logic [AW-1:0]         flash_addr,
    input  wire logic [DW-1:0]    flash_dq_i,
    output logic [DW-1:0]         flash_dq_o,
    output logic                  flash_dq_oe
);

    initial
    begin
        if (POLL_MAX < 2 || POLL_MAX > 65535)
            $error("fsp_host_ctrl: POLL_MAX out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycle engine.

    logic          bus_start;
    logic          bus_wr;
    logic [AW-1:0] bus_addr;
    logic [DW-1:0] bus_wdata;
    logic          bus_done;
    logic [DW-1:0] bus_rdata;

    fsp_bus_cycle #(.AW(AW), .DW(DW)) u_bus (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .clk_en      (clk_en),
        .start       (bus_start),
        .is_wr       (bus_wr),
        .addr        (bus_addr),
        .wdata       (bus_wdata),
        .done        (bus_done),
        .rdata       (bus_rdata),
        .flash_ce_n  (flash_ce_n),
        .flash_oe_n  (flash_oe_n),
        .flash_we_n  (flash_we_n),
        .flash_addr  (flash_addr),
        .flash_dq_i  (flash_dq_i),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Operation sequencer.

    fsp_pkg::fsp_hs_t st_r, st_nxt;
    fsp_pkg::fsp_op_t op_r, op_nxt;
    logic             busy_r, busy_nxt;
    logic [AW-1:0]    addr_r, addr_nxt;
    logic [DW-1:0]    data_r, data_nxt;
    logic [DW-1:0]    samp_a_r, samp_a_nxt;
    logic [DW-1:0]    samp_b_r, samp_b_nxt;
    logic [15:0]      cnt_r, cnt_nxt;
    logic             rv_r, rv_nxt;
    logic [DW-1:0]    rd_r, rd_nxt;
    logic             rrdy_r, rrdy_nxt;
    logic             rfail_r, rfail_nxt;
    logic             rto_r, rto_nxt;
    logic             rtg2_r, rtg2_nxt;
    logic             rtmr_r, rtmr_nxt;
    logic             toggling;
    logic             at_limit;
    logic             st_ready;
    logic             poll_word;
    logic             prev_poll;

    assign toggling = samp_a_r[fsp_pkg::BIT_TOGGLE_ONE] ^ bus_rdata[fsp_pkg::BIT_TOGGLE_ONE];
    assign at_limit = (cnt_r >= 16'(POLL_MAX));
    assign st_ready = bus_rdata[fsp_pkg::BIT_READY];
    // A read whose bit 7 differs from the expected true bit is still a status word.
    assign poll_word = (bus_rdata[fsp_pkg::BIT_POLLING] != data_r[fsp_pkg::BIT_POLLING]);
    assign prev_poll = (samp_a_r[fsp_pkg::BIT_POLLING] != data_r[fsp_pkg::BIT_POLLING]);

    always_comb
    begin
        st_nxt     = st_r;
        op_nxt     = op_r;
        busy_nxt   = busy_r;
        addr_nxt   = addr_r;
        data_nxt   = data_r;
        samp_a_nxt = samp_a_r;
        samp_b_nxt = samp_b_r;
        cnt_nxt    = cnt_r;
        rv_nxt     = 1'b0;
        rd_nxt     = rd_r;
        rrdy_nxt   = rrdy_r;
        rfail_nxt  = rfail_r;
        rto_nxt    = rto_r;
        rtg2_nxt   = rtg2_r;
        rtmr_nxt   = rtmr_r;
        bus_start  = 1'b0;
        bus_wr     = 1'b0;
        bus_addr   = addr_r;
        bus_wdata  = data_r;
        case (st_r)
            fsp_pkg::HS_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_nxt    = cmd_op;
                    addr_nxt  = cmd_addr;
                    data_nxt  = cmd_data;
                    cnt_nxt   = 16'h0000;
                    rfail_nxt = 1'b0;
                    rto_nxt   = 1'b0;
                    rtg2_nxt  = 1'b0;
                    rtmr_nxt  = 1'b0;
                    case (cmd_op)
                        fsp_pkg::OP_WRITE:   st_nxt = fsp_pkg::HS_WR;
                        fsp_pkg::OP_SUSPEND: st_nxt = fsp_pkg::HS_WR;
                        fsp_pkg::OP_READ:    st_nxt = fsp_pkg::HS_RD;
                        fsp_pkg::OP_STATUS:  st_nxt = fsp_pkg::HS_ST_CMD;
                        fsp_pkg::OP_POLL:    st_nxt = fsp_pkg::HS_POLL_A;
                        default:             st_nxt = fsp_pkg::HS_WR;
                    endcase
                end
            end
            fsp_pkg::HS_WR:
            begin
                bus_start = !busy_r;
                bus_wr    = 1'b1;
                busy_nxt  = !bus_done;
                if (bus_done)
                    st_nxt = (op_r == fsp_pkg::OP_SUSPEND) ? fsp_pkg::HS_ST_CMD
                                                           : fsp_pkg::HS_DONE;
            end
            fsp_pkg::HS_RD:
            begin
                bus_start = !busy_r;
                busy_nxt  = !bus_done;
                if (bus_done)
                begin
                    rd_nxt = bus_rdata;
                    st_nxt = fsp_pkg::HS_DONE;
                end
            end
            fsp_pkg::HS_ST_CMD:
            begin
                bus_start = !busy_r;
                bus_wr    = 1'b1;
                bus_addr  = AW'(fsp_pkg::CMD_STATUS_ADDR);
                bus_wdata = fsp_pkg::CMD_STATUS_READ;
                busy_nxt  = !bus_done;
                if (bus_done)
                    st_nxt = fsp_pkg::HS_ST_RD;
            end
            fsp_pkg::HS_ST_RD:
            begin
                bus_start = !busy_r;
                busy_nxt  = !bus_done;
                if (bus_done)
                begin
                    rrdy_nxt = st_ready;
                    cnt_nxt  = cnt_r + 16'h0001;
                    // Reserved high byte dropped; flags 6 to 1 are meaningless while busy.
                    rd_nxt = st_ready ? (bus_rdata & fsp_pkg::STATUS_KEEP_MASK)
                                      : (bus_rdata & fsp_pkg::NOT_READY_MASK);
                    if (op_r == fsp_pkg::OP_SUSPEND && !st_ready && !at_limit)
                        st_nxt = fsp_pkg::HS_ST_CMD;
                    else
                    begin
                        rto_nxt = (op_r == fsp_pkg::OP_SUSPEND) && !st_ready;
                        st_nxt  = fsp_pkg::HS_DONE;
                    end
                end
            end
            fsp_pkg::HS_POLL_A:
            begin
                // Polling only starts after the command's write cycles ended.
                bus_start = !busy_r;
                busy_nxt  = !bus_done;
                if (bus_done)
                begin
                    samp_a_nxt = bus_rdata & fsp_pkg::POLL_KEEP_MASK;
                    st_nxt     = fsp_pkg::HS_POLL_B;
                end
            end
            fsp_pkg::HS_POLL_B:
            begin
                bus_start = !busy_r;
                busy_nxt  = !bus_done;
                if (bus_done)
                begin
                    samp_b_nxt = bus_rdata & fsp_pkg::POLL_KEEP_MASK;
                    samp_a_nxt = bus_rdata & fsp_pkg::POLL_KEEP_MASK;
                    cnt_nxt    = cnt_r + 16'h0001;
                    // Only a pair of status words says anything about toggle bit two.
                    if (poll_word && prev_poll)
                        rtg2_nxt = rtg2_r | (samp_a_r[fsp_pkg::BIT_TOGGLE_TWO]
                                             ^ bus_rdata[fsp_pkg::BIT_TOGGLE_TWO]);
                    if (poll_word)
                        rtmr_nxt = bus_rdata[fsp_pkg::BIT_ERASE_TIMER];
                    // Toggle bit one stopping marks the end of the algorithm.
                    if (toggling && !at_limit)
                        st_nxt = fsp_pkg::HS_POLL_B;
                    else
                    begin
                        rto_nxt = toggling;
                        st_nxt  = fsp_pkg::HS_POLL_C;
                    end
                end
            end
            fsp_pkg::HS_POLL_C:
            begin
                // Data is trusted only from a read after the status settled.
                bus_start = !busy_r;
                busy_nxt  = !bus_done;
                if (bus_done)
                begin
                    rd_nxt    = bus_rdata;
                    // True bit 7 must match the expected one: programmed bit, or 1 for erase.
                    rfail_nxt = rto_r || (bus_rdata[fsp_pkg::BIT_POLLING]
                                          != data_r[fsp_pkg::BIT_POLLING]);
                    st_nxt    = fsp_pkg::HS_DONE;
                end
            end
            fsp_pkg::HS_DONE:
            begin
                rv_nxt = 1'b1;
                st_nxt = fsp_pkg::HS_IDLE;
            end
            default: st_nxt = fsp_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r     <= fsp_pkg::HS_IDLE;
            op_r     <= fsp_pkg::OP_WRITE;
            busy_r   <= 1'b0;
            addr_r   <= '0;
            data_r   <= '0;
            samp_a_r <= '0;
            samp_b_r <= '0;
            cnt_r    <= 16'h0000;
            rv_r     <= 1'b0;
            rd_r     <= '0;
            rrdy_r   <= 1'b0;
            rfail_r  <= 1'b0;
            rto_r    <= 1'b0;
            rtg2_r   <= 1'b0;
            rtmr_r   <= 1'b0;
        end
        else if (clk_en)
        begin
            st_r     <= st_nxt;
            op_r     <= op_nxt;
            busy_r   <= busy_nxt;
            addr_r   <= addr_nxt;
            data_r   <= data_nxt;
            samp_a_r <= samp_a_nxt;
            samp_b_r <= samp_b_nxt;
            cnt_r    <= cnt_nxt;
            rv_r     <= rv_nxt;
            rd_r     <= rd_nxt;
            rrdy_r   <= rrdy_nxt;
            rfail_r  <= rfail_nxt;
            rto_r    <= rto_nxt;
            rtg2_r   <= rtg2_nxt;
            rtmr_r   <= rtmr_nxt;
        end
    end

    assign cmd_ready       = (st_r == fsp_pkg::HS_IDLE);
    assign rsp_valid       = rv_r;
    assign rsp_data        = rd_r;
    assign rsp_ready_flag  = rrdy_r;
    assign rsp_fail        = rfail_r;
    assign rsp_timeout     = rto_r;
    assign rsp_toggle_two  = rtg2_r;
    assign rsp_erase_timer = rtmr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    reserved_mask_a: assert property (
        rv_r && op_r == fsp_pkg::OP_STATUS |-> rd_r[15:8] == 8'h00)
        else $error("reserved status bits not masked");
    busy_flags_a: assert property (
        rv_r && op_r == fsp_pkg::OP_STATUS && !rrdy_r |-> rd_r[6:1] == 6'h00)
        else $error("status flags passed while busy");
    suspend_ready_a: assert property (
        rv_r && op_r == fsp_pkg::OP_SUSPEND && !rto_r |-> rrdy_r)
        else $error("suspend finished before ready");
    poll_mask_a: assert property (
        (samp_b_r & ~fsp_pkg::POLL_KEEP_MASK) == 16'h0000)
        else $error("reserved polling bits kept");
    final_read_a: assert property (
        st_r == fsp_pkg::HS_POLL_B && st_nxt == fsp_pkg::HS_POLL_C && clk_en
        |=> st_r == fsp_pkg::HS_POLL_C ##[1:4] !flash_oe_n)
        else $error("no extra read after polling settled");
    poll_start_a: assert property (
        st_r == fsp_pkg::HS_POLL_A |-> flash_we_n)
        else $error("polling read overlaps write strobe");
    poll_bound_a: assert property (
        {1'b0, cnt_r} <= 17'(POLL_MAX) + 17'h00001)
        else $error("poll count beyond limit");
    one_pulse_a: assert property (
        rv_r |=> !rv_r)
        else $error("response held longer than one cycle");

endmodule : fsp_host_ctrl

//--- fsp_flash_model.sv
// Behavioural flash: status capture, polling word, program, erase and suspend.
// Assumes host strobes; words 8 to 15 form a protected sector.
`timescale 1ns/10ps
module fsp_flash_model (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [25:0] addr,
    input  wire logic [15:0] din,
    output logic      [15:0] dout
);
    logic [15:0] mem [16];
    logic [15:0] sr = 16'h0080;
    logic [15:0] rd = 16'h0000;
    logic [15:0] pd = 16'h0000;
    logic [7:0]  jk = 8'h5A;
    logic [3:0]  pa = 4'h0;
    logic        we_low = 1'h0;
    logic        busy = 1'h0, er = 1'h0, sm = 1'h0, ps = 1'h0, tg = 1'h0, tm = 1'h0;
    int          cnt = 0;
    // A released bus shows the inverse of the last word, so stale data never passes.
    assign dout = (!ce_n && !oe_n) ? rd : ~rd;
    initial
        foreach (mem[i]) mem[i] = 16'h0000;
    always @(negedge we_n)
        we_low = 1'h1;
    // The x-to-1 step of the write strobe at reset is not taken as a write.
    always @(posedge we_n)
    begin
        if (!we_low)
            sm = sm;
        else if (din == 16'h0070 && addr == 26'h555)
            sm = 1'h1;
        else if (busy && din == 16'h00B0)
        begin
            ps  = 1'h1;
            cnt = 2;
        end
        else if (!busy && din == 16'h0071)
            sr = sr & 16'hFFC5;
        else if (!busy && din == 16'h00F0)
            sr = sr[3] ? sr : (sr & 16'hFFCC);
        else if (!busy && ps && din == 16'h0031)
        begin
            ps             = 1'h0;
            sr[er ? 6 : 2] = 1'h0;
            sr[7]          = 1'h0;
            busy           = 1'h1;
            cnt            = 2;
        end
        else if (ps && er && addr[3] == pa[3])
            sm = sm;
        else if (!busy)
        begin
            busy  = 1'h1;
            er    = (din == 16'h0030);
            pd    = din;
            pa    = addr[3:0];
            tm    = 1'h0;
            cnt   = er ? 4 : 3;
            sr[7] = 1'h0;
        end
        we_low = 1'h0;
    end
    always @(negedge oe_n)
    begin
        jk = jk + 8'h3B;
        if (sm)
            rd = {jk, sr[7:0]};
        else if (busy)
        begin
            tg = ~tg;
            rd = {jk, er ? 1'h0 : ~pd[7], tg, 1'h0, jk[0], tm,
                  er && addr[3] == pa[3] && tg, 1'h0, jk[1]};
            tm = 1'h1;
        end
        else
            rd = mem[addr[3:0]];
        sm = 1'h0;
        if (busy)
            cnt = cnt - 1;
        if (busy && cnt == 0)
        begin
            busy  = 1'h0;
            sr[7] = 1'h1;
            if (ps)
                sr[er ? 6 : 2] = 1'h1;
            else
            begin
                sr[1] = pa[3];
                if (er)
                    sr[5] = pa[3];
                else
                    sr[4] = pa[3];
                for (int i = 0; i < 16; i++)
                    if (!pa[3] && (er ? i[3] == pa[3] : i == pa))
                        mem[i] = er ? 16'hFFFF : pd;
            end
        end
    end
endmodule : fsp_flash_model

//--- tb.sv
// Self-checking bench: host controller driving the behavioural flash model.
// Assumes the package, design and model files are compiled first.
`timescale 1ns/10ps
module tb;
    logic             clk_sys = 1'h0;
    logic             nrst = 1'h0;
    logic             cmd_valid = 1'h0;
    logic             cmd_ready, rsp_valid, rsp_ready_flag, rsp_fail, rsp_timeout;
    logic             rsp_toggle_two, rsp_erase_timer, ce_n, oe_n, we_n, dq_oe;
    fsp_pkg::fsp_op_t cmd_op = fsp_pkg::OP_READ;
    logic [25:0]      cmd_addr = 26'h0, fa;
    logic [15:0]      cmd_data = 16'h0, rsp_data, dq_o, mdq;
    wire  [15:0]      dq = dq_oe ? dq_o : mdq;
    int               n_mismatch = 0, checks = 0, cyc = 0;
    fsp_host_ctrl #(.POLL_MAX(8)) dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'h1),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ready_flag(rsp_ready_flag), .rsp_fail(rsp_fail), .rsp_timeout(rsp_timeout),
        .rsp_toggle_two(rsp_toggle_two), .rsp_erase_timer(rsp_erase_timer),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
        .flash_dq_i(dq), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe));
    fsp_flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa),
        .din(dq), .dout(mdq));
    initial
        forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Issue one operation at a falling edge and wait for its response pulse.
    task automatic op(input fsp_pkg::fsp_op_t o, input logic [25:0] a, input logic [15:0] d);
        cmd_op    = o;
        cmd_addr  = a;
        cmd_data  = d;
        cmd_valid = 1'h1;
        @(negedge clk_sys);
        cmd_valid = 1'h0;
        while (rsp_valid !== 1'h1)
            @(negedge clk_sys);
    endtask : op
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(negedge clk_sys);
        nrst = 1'h1;
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h0080);
        chk(rsp_ready_flag, 1'h1);
        op(fsp_pkg::OP_WRITE, 26'h3, 16'h00A5);
        op(fsp_pkg::OP_POLL, 26'h3, 16'h00A5);
        chk(rsp_data, 16'h00A5);
        chk(rsp_fail, 1'h0);
        chk(rsp_toggle_two, 1'h0);
        op(fsp_pkg::OP_WRITE, 26'h9, 16'h0080);
        op(fsp_pkg::OP_POLL, 26'h9, 16'h0080);
        chk(rsp_data, 16'h0000);
        chk(rsp_fail, 1'h1);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h0092);
        op(fsp_pkg::OP_WRITE, 26'h2, 16'h0030);
        op(fsp_pkg::OP_POLL, 26'h2, 16'h0080);
        chk(rsp_data, 16'hFFFF);
        chk(rsp_toggle_two, 1'h1);
        chk(rsp_erase_timer, 1'h1);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h0090);
        op(fsp_pkg::OP_WRITE, 26'h3, 16'h0055);
        op(fsp_pkg::OP_SUSPEND, 26'h3, 16'h00B0);
        chk(rsp_data, 16'h0094);
        chk(rsp_timeout, 1'h0);
        op(fsp_pkg::OP_READ, 26'h3, 16'h0);
        chk(rsp_data, 16'hFFFF);
        op(fsp_pkg::OP_WRITE, 26'h555, 16'h0071);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h0084);
        op(fsp_pkg::OP_WRITE, 26'h3, 16'h0031);
        op(fsp_pkg::OP_POLL, 26'h3, 16'h0055);
        chk(rsp_data, 16'h0055);
        chk(rsp_toggle_two, 1'h0);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h0080);
        op(fsp_pkg::OP_WRITE, 26'h9, 16'h0030);
        op(fsp_pkg::OP_POLL, 26'h9, 16'h0080);
        chk(rsp_fail, 1'h1);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h00A2);
        op(fsp_pkg::OP_WRITE, 26'h555, 16'h00F0);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h0080);
        op(fsp_pkg::OP_WRITE, 26'h2, 16'h0030);
        op(fsp_pkg::OP_SUSPEND, 26'h2, 16'h00B0);
        chk(rsp_data, 16'h00C0);
        op(fsp_pkg::OP_WRITE, 26'h2, 16'h0011);
        op(fsp_pkg::OP_READ, 26'h2, 16'h0);
        chk(rsp_data, 16'hFFFF);
        op(fsp_pkg::OP_STATUS, 26'h0, 16'h0);
        chk(rsp_data, 16'h00C0);
        report_and_stop();
    end
endmodule : tb
